/* File: img_xfer_cfg.svh */
// constants for the image window transfer engine
`ifndef IMG_XFER_CFG_SVH
`define IMG_XFER_CFG_SVH

// opcode word: command in the high byte, flags in the low byte
`define IWT_OPC_MSB 15
`define IWT_OPC_LSB 8
`define IWT_OP_WRITE 8'h0A
`define IWT_OP_READ 8'h0B
`define IWT_OF_BIT 0
`define IWT_DF_BIT 1
`define IWT_BK_BIT 2
`define IWT_IX_MSB 4
`define IWT_IX_LSB 3
`define IWT_IX_NONE 2'h0
`define IWT_IX_ONE 2'h1
`define IWT_IX_TWO 2'h2

// operand flag word bits
`define IWT_SCN_BIT 7
`define IWT_WIN_BIT 6
`define IWT_SP_BIT 5

// operand order: scan, left, top, right, bottom, start x, start y
`define IWT_OPND_SCAN 3'h0
`define IWT_OPND_LEFT 3'h1
`define IWT_OPND_TOP 3'h2
`define IWT_OPND_RIGHT 3'h3
`define IWT_OPND_BOTTOM 3'h4
`define IWT_OPND_SX 3'h5
`define IWT_OPND_SY 3'h6
`define IWT_OPND_DONE 3'h7

// reset values and readback format
`define IWT_SCAN_RST 3'h0
`define IWT_COORD_RST 10'h000
`define IWT_RD_FORCE 16'hF000

// readback buffer shape
`define IWT_FIFO_WIDTH 16
`define IWT_FIFO_DEPTH 32

`endif

/* File: img_xfer_pkg.sv */
// types shared by the image window transfer engine
package img_xfer_pkg;

    typedef logic [9:0] coord_t;

    typedef struct packed {
        coord_t x;
        coord_t y;
    } point_t;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_FLAGS = 9'h002,
        ST_OPER = 9'h004,
        ST_SETUP = 9'h008,
        ST_LEN = 9'h010,
        ST_WR_DATA = 9'h020,
        ST_RD_ISSUE = 9'h040,
        ST_RD_WAIT = 9'h080,
        ST_RD_PUSH = 9'h100
    } state_t;

endpackage

/* File: fifo_if.sv */
// valid/ready carrier between the engine and its readback buffer
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(
    parameter int WIDTH = 16
);
    logic pushValid;
    logic pushReady;
    logic [WIDTH-1:0] pushData;
    logic popValid;
    logic popReady;
    logic [WIDTH-1:0] popData;

    modport user (
        output pushValid, pushData, popReady,
        input pushReady, popValid, popData
    );
    modport store (
        input pushValid, pushData, popReady,
        output pushReady, popValid, popData
    );
endinterface
`default_nettype wire

/* File: word_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // both sides of the buffer
    fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrIdx_r;
    logic [AW-1:0] rdIdx_r;
    logic [AW:0] count_r;
    logic doPush;
    logic doPop;

    // full and empty come straight from the occupancy count
    assign f.pushReady = (count_r != (AW+1)'(DEPTH));
    assign f.popValid = (count_r != '0);
    assign f.popData = mem[rdIdx_r];
    assign doPush = f.pushValid && f.pushReady;
    assign doPop = f.popValid && f.popReady;

    // storage has no reset; only the indices and the occupancy count are reset
    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem[wrIdx_r] <= f.pushData;
        end
    end

    // write index wraps at the depth, which need not be a power of two
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wrIdx_r <= '0;
        end else if (doPush) begin
            wrIdx_r <= (wrIdx_r == AW'(DEPTH-1)) ? '0 : AW'(wrIdx_r + 1'b1);
        end
    end

    // read index
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdIdx_r <= '0;
        end else if (doPop) begin
            rdIdx_r <= (rdIdx_r == AW'(DEPTH-1)) ? '0 : AW'(rdIdx_r + 1'b1);
        end
    end

    // occupancy
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_r <= '0;
        end else if (doPush && !doPop) begin
            count_r <= (AW+1)'(count_r + 1'b1);
        end else if (doPop && !doPush) begin
            count_r <= (AW+1)'(count_r - 1'b1);
        end
    end

    chk_fifo_count_up: assert property (@(posedge sys_clk) disable iff (!rstn)
        (doPush && !doPop) |=> count_r == (AW+1)'($past(count_r) + 1'b1))
        else $error("fifo count did not rise on push");

    chk_fifo_full_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!f.pushReady && !doPop) |=> !f.pushReady)
        else $error("fifo left full without a pop");
endmodule
`default_nettype wire

/* File: image_window_transfer.sv */
// image write/read engine walking a window of refresh memory
//
// Behaviour
// - after write, point sits at word N+1
// - exact fill returns point to start pixel
// - excess words keep wrapping over window
// - eight scan modes pick directions and corner
// - scan operand taken as value 0 to 7
// - read: instruction first, then host pulls words
// - read without length word returns nothing
// - read instruction alone pushes no data
// - read returns up to 32767 window pixels
// - first word from start point, window corner or current point
// - primary edge: wrap, step secondary once
// - secondary edge wraps to opposite edge
// - write inhibit ignored; color flag forces foreground
// - readback ignores plane mask, all planes
// - twelve planes; absent planes read anything
// - readback upper four bits forced to one
// - index select governs offsets, window, start
// - index one displaces window and start
// - index two displaces window and start
// - window but no start point: corner chosen by scan
// - odd byte count dropped to even
// - after read, point sits at word N+1
`timescale 1ns/1ps
`default_nettype none
`include "img_xfer_cfg.svh"
module image_window_transfer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // instruction and write-data words from the host
    input wire logic cmdValid,
    input wire logic [15:0] cmdWord,
    output logic cmdReady,
    // readback words to the host
    output logic hostRdValid,
    output logic [15:0] hostRdData,
    input wire logic hostRdReady,
    // drawing state held outside this block
    input wire logic [11:0] subchannel,
    input wire logic [11:0] foreground,
    input wire logic [9:0] index1X,
    input wire logic [9:0] index1Y,
    input wire logic [9:0] index2X,
    input wire logic [9:0] index2Y,
    // refresh memory port
    output logic [9:0] memAddrX,
    output logic [9:0] memAddrY,
    output logic memWe,
    output logic [11:0] memWdata,
    output logic [11:0] memWmask,
    output logic memRd,
    input wire logic memRdValid,
    input wire logic [11:0] memRdData,
    // status
    output logic busy,
    output logic [9:0] copX,
    output logic [9:0] copY
);
    img_xfer_pkg::state_t state_r;
    img_xfer_pkg::state_t state_nxt;
    img_xfer_pkg::point_t cop_r;
    img_xfer_pkg::point_t start_r;
    img_xfer_pkg::coord_t winL_r;
    img_xfer_pkg::coord_t winT_r;
    img_xfer_pkg::coord_t winR_r;
    img_xfer_pkg::coord_t winB_r;
    logic [2:0] scan_r;
    logic [2:0] opIdx_r;
    logic [2:0] opIdx_nxt;
    logic [2:0] en_r;
    logic read_r;
    logic df_r;
    logic bk_r;
    logic [1:0] ix_r;
    logic [14:0] wordsLeft_r;
    logic cmdReady_r;
    logic memWe_r;
    logic memRd_r;
    logic [9:0] memAddrX_r;
    logic [9:0] memAddrY_r;
    logic [11:0] memWdata_r;
    logic [11:0] memWmask_r;
    logic pushValid_r;
    logic [15:0] pushData_r;
    logic hostRdValid_r;
    logic [15:0] hostRdData_r;
    logic busy_r;
    logic take;
    logic [7:0] opcode;
    img_xfer_pkg::coord_t offX;
    img_xfer_pkg::coord_t offY;

    fifo_if #(.WIDTH(`IWT_FIFO_WIDTH)) rdq ();

    word_fifo #(
        .WIDTH(`IWT_FIFO_WIDTH),
        .DEPTH(`IWT_FIFO_DEPTH)
    ) u_rdq (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .f(rdq.store)
    );

    // one step along an axis: {wrapped, next}; wraps at the far edge
    function automatic logic [10:0] axisStep(img_xfer_pkg::coord_t pos,
            logic neg, img_xfer_pkg::coord_t lo, img_xfer_pkg::coord_t hi);
        if (pos == (neg ? lo : hi)) begin
            axisStep = {1'b1, (neg ? hi : lo)};
        end else if (neg) begin
            axisStep = {1'b0, 10'(pos - 10'h001)};
        end else begin
            axisStep = {1'b0, 10'(pos + 10'h001)};
        end
    endfunction

    // mode bit 2 transposes; the low bits mirror x and y
    function automatic logic [1:0] scanNeg(logic [2:0] m);
        scanNeg = m[2] ? {m[1], m[0]} : {m[0], m[1]};
    endfunction

    // next pixel in scan order, wrapping inside the window
    function automatic img_xfer_pkg::point_t stepPoint(
            img_xfer_pkg::point_t p, logic [2:0] m,
            img_xfer_pkg::coord_t l, img_xfer_pkg::coord_t t,
            img_xfer_pkg::coord_t r, img_xfer_pkg::coord_t b);
        logic [1:0] neg;
        logic [10:0] sx;
        logic [10:0] sy;
        neg = scanNeg(m);
        sx = axisStep(p.x, neg[1], l, r);
        sy = axisStep(p.y, neg[0], t, b);
        stepPoint = p;
        if (!m[2]) begin
            stepPoint.x = sx[9:0];
            if (sx[10]) begin
                stepPoint.y = sy[9:0];
            end
        end else begin
            stepPoint.y = sy[9:0];
            if (sy[10]) begin
                stepPoint.x = sx[9:0];
            end
        end
    endfunction

    // starting corner implied by the scan mode
    function automatic img_xfer_pkg::point_t corner(logic [2:0] m,
            img_xfer_pkg::coord_t l, img_xfer_pkg::coord_t t,
            img_xfer_pkg::coord_t r, img_xfer_pkg::coord_t b);
        logic [1:0] neg;
        neg = scanNeg(m);
        corner.x = neg[1] ? r : l;
        corner.y = neg[0] ? b : t;
    endfunction

    // first operand slot at or after 'from' that the flags enable
    function automatic logic [2:0] nextOpnd(logic [2:0] from, logic [2:0] en);
        logic hit;
        logic [1:0] g;
        hit = 1'b0;
        nextOpnd = `IWT_OPND_DONE;
        for (int i = 0; i < 7; i++) begin
            g = (i == 0) ? 2'h0 : ((i < 5) ? 2'h1 : 2'h2);
            if (!hit && 3'(i) >= from && en[g]) begin
                hit = 1'b1;
                nextOpnd = 3'(i);
            end
        end
    endfunction

    assign take = cmdValid && cmdReady_r;
    assign opcode = cmdWord[`IWT_OPC_MSB:`IWT_OPC_LSB];
    assign opIdx_nxt = nextOpnd(3'(opIdx_r + 3'h1), en_r);

    // displacement picked by the index select of this instruction
    always_comb begin
        offX = `IWT_COORD_RST;
        offY = `IWT_COORD_RST;
        if (ix_r == `IWT_IX_ONE) begin
            offX = index1X;
            offY = index1Y;
        end else if (ix_r == `IWT_IX_TWO) begin
            offX = index2X;
            offY = index2Y;
        end
    end

    // instruction sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            img_xfer_pkg::ST_IDLE: begin
                if (take && (opcode == `IWT_OP_WRITE ||
                        opcode == `IWT_OP_READ)) begin
                    state_nxt = cmdWord[`IWT_OF_BIT] ?
                        img_xfer_pkg::ST_FLAGS : img_xfer_pkg::ST_SETUP;
                end
            end
            img_xfer_pkg::ST_FLAGS: begin
                if (take) begin
                    state_nxt = (nextOpnd(3'h0, {cmdWord[`IWT_SP_BIT],
                        cmdWord[`IWT_WIN_BIT], cmdWord[`IWT_SCN_BIT]})
                        == `IWT_OPND_DONE) ?
                        img_xfer_pkg::ST_SETUP : img_xfer_pkg::ST_OPER;
                end
            end
            img_xfer_pkg::ST_OPER: begin
                if (take && opIdx_nxt == `IWT_OPND_DONE) begin
                    state_nxt = img_xfer_pkg::ST_SETUP;
                end
            end
            img_xfer_pkg::ST_SETUP: begin
                // no length word means no data phase at all
                state_nxt = df_r ? img_xfer_pkg::ST_LEN :
                    img_xfer_pkg::ST_IDLE;
            end
            img_xfer_pkg::ST_LEN: begin
                if (take) begin
                    if (cmdWord[15:1] == 15'h0000) begin
                        state_nxt = img_xfer_pkg::ST_IDLE;
                    end else begin
                        state_nxt = read_r ? img_xfer_pkg::ST_RD_ISSUE :
                            img_xfer_pkg::ST_WR_DATA;
                    end
                end
            end
            img_xfer_pkg::ST_WR_DATA: begin
                if (take && wordsLeft_r == 15'h0001) begin
                    state_nxt = img_xfer_pkg::ST_IDLE;
                end
            end
            img_xfer_pkg::ST_RD_ISSUE: begin
                // only fetch while the buffer has room
                if (rdq.pushReady) begin
                    state_nxt = img_xfer_pkg::ST_RD_WAIT;
                end
            end
            img_xfer_pkg::ST_RD_WAIT: begin
                if (memRdValid) begin
                    state_nxt = img_xfer_pkg::ST_RD_PUSH;
                end
            end
            img_xfer_pkg::ST_RD_PUSH: begin
                if (rdq.pushReady) begin
                    state_nxt = (wordsLeft_r == 15'h0001) ?
                        img_xfer_pkg::ST_IDLE : img_xfer_pkg::ST_RD_ISSUE;
                end
            end
            default: begin
                state_nxt = img_xfer_pkg::ST_IDLE;
            end
        endcase
    end

    // state, host ready and busy follow the next state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= img_xfer_pkg::ST_IDLE;
            cmdReady_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmdReady_r <= (state_nxt == img_xfer_pkg::ST_IDLE) ||
                (state_nxt == img_xfer_pkg::ST_FLAGS) ||
                (state_nxt == img_xfer_pkg::ST_OPER) ||
                (state_nxt == img_xfer_pkg::ST_LEN) ||
                (state_nxt == img_xfer_pkg::ST_WR_DATA);
            busy_r <= (state_nxt != img_xfer_pkg::ST_IDLE);
        end
    end

    // opcode flags and operand bookkeeping
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            read_r <= 1'b0;
            df_r <= 1'b0;
            bk_r <= 1'b0;
            ix_r <= `IWT_IX_NONE;
            en_r <= 3'h0;
            opIdx_r <= `IWT_OPND_DONE;
        end else if (take && state_r == img_xfer_pkg::ST_IDLE) begin
            read_r <= (opcode == `IWT_OP_READ);
            df_r <= cmdWord[`IWT_DF_BIT];
            bk_r <= cmdWord[`IWT_BK_BIT];
            ix_r <= cmdWord[`IWT_IX_MSB:`IWT_IX_LSB];
            en_r <= 3'h0;
        end else if (take && state_r == img_xfer_pkg::ST_FLAGS) begin
            en_r <= {cmdWord[`IWT_SP_BIT], cmdWord[`IWT_WIN_BIT],
                cmdWord[`IWT_SCN_BIT]};
            opIdx_r <= nextOpnd(3'h0, {cmdWord[`IWT_SP_BIT],
                cmdWord[`IWT_WIN_BIT], cmdWord[`IWT_SCN_BIT]});
        end else if (take && state_r == img_xfer_pkg::ST_OPER) begin
            opIdx_r <= opIdx_nxt;
        end
    end

    // scan, window and start operands; window and start are displaced
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scan_r <= `IWT_SCAN_RST;
            winL_r <= `IWT_COORD_RST;
            winT_r <= `IWT_COORD_RST;
            winR_r <= `IWT_COORD_RST;
            winB_r <= `IWT_COORD_RST;
            start_r <= '0;
        end else if (take && state_r == img_xfer_pkg::ST_OPER) begin
            unique case (opIdx_r)
                `IWT_OPND_SCAN: scan_r <= cmdWord[2:0];
                `IWT_OPND_LEFT: winL_r <= 10'(cmdWord[9:0] + offX);
                `IWT_OPND_TOP: winT_r <= 10'(cmdWord[9:0] + offY);
                `IWT_OPND_RIGHT: winR_r <= 10'(cmdWord[9:0] + offX);
                `IWT_OPND_BOTTOM: winB_r <= 10'(cmdWord[9:0] + offY);
                `IWT_OPND_SX: start_r.x <= 10'(cmdWord[9:0] + offX);
                `IWT_OPND_SY: start_r.y <= 10'(cmdWord[9:0] + offY);
                default: begin
                end
            endcase
        end
    end

    // current point: set at setup when a start or window is given, stepped per pixel
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cop_r <= '0;
        end else if (state_r == img_xfer_pkg::ST_SETUP) begin
            if (en_r[2]) begin
                cop_r <= start_r;
            end else if (en_r[1]) begin
                cop_r <= corner(scan_r, winL_r, winT_r, winR_r,
                    winB_r);
            end
        end else if ((take && state_r == img_xfer_pkg::ST_WR_DATA) ||
                (state_r == img_xfer_pkg::ST_RD_ISSUE && rdq.pushReady)) begin
            // stepping after every pixel leaves the point on word N+1,
            // which is the start pixel again after an exact fill
            cop_r <= stepPoint(cop_r, scan_r, winL_r, winT_r, winR_r,
                winB_r);
        end
    end

    // remaining words; odd byte counts lose their last byte
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wordsLeft_r <= 15'h0000;
        end else if (take && state_r == img_xfer_pkg::ST_LEN) begin
            wordsLeft_r <= cmdWord[15:1];
        end else if ((take && state_r == img_xfer_pkg::ST_WR_DATA) ||
                (state_r == img_xfer_pkg::ST_RD_PUSH && rdq.pushReady)) begin
            wordsLeft_r <= 15'(wordsLeft_r - 15'h0001);
        end
    end

    // memory strobes; write inhibit has no path here by design
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            memWe_r <= 1'b0;
            memRd_r <= 1'b0;
            memAddrX_r <= `IWT_COORD_RST;
            memAddrY_r <= `IWT_COORD_RST;
            memWdata_r <= 12'h000;
            memWmask_r <= 12'h000;
        end else begin
            memWe_r <= take && state_r == img_xfer_pkg::ST_WR_DATA;
            memRd_r <= state_r == img_xfer_pkg::ST_RD_ISSUE &&
                rdq.pushReady;
            if ((take && state_r == img_xfer_pkg::ST_WR_DATA) ||
                    state_r == img_xfer_pkg::ST_RD_ISSUE) begin
                memAddrX_r <= cop_r.x;
                memAddrY_r <= cop_r.y;
                memWdata_r <= bk_r ? foreground : cmdWord[11:0];
                memWmask_r <= subchannel;
            end
        end
    end

    // readback word: all twelve planes, top nibble forced high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pushValid_r <= 1'b0;
            pushData_r <= 16'h0000;
        end else if (state_r == img_xfer_pkg::ST_RD_WAIT && memRdValid) begin
            pushValid_r <= 1'b1;
            pushData_r <= `IWT_RD_FORCE | {4'h0, memRdData};
        end else if (rdq.pushReady) begin
            pushValid_r <= 1'b0;
        end
    end

    assign rdq.pushValid = pushValid_r;
    assign rdq.pushData = pushData_r;
    // output stage refills whenever empty or drained by the host
    assign rdq.popReady = !hostRdValid_r || hostRdReady;

    // registered host readback stage
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hostRdValid_r <= 1'b0;
            hostRdData_r <= 16'h0000;
        end else if (!hostRdValid_r || hostRdReady) begin
            hostRdValid_r <= rdq.popValid;
            hostRdData_r <= rdq.popData;
        end
    end

    assign cmdReady = cmdReady_r;
    assign hostRdValid = hostRdValid_r;
    assign hostRdData = hostRdData_r;
    assign memAddrX = memAddrX_r;
    assign memAddrY = memAddrY_r;
    assign memWe = memWe_r;
    assign memWdata = memWdata_r;
    assign memWmask = memWmask_r;
    assign memRd = memRd_r;
    assign busy = busy_r;
    assign copX = cop_r.x;
    assign copY = cop_r.y;

    chk_readback_ones: assert property (@(posedge sys_clk) disable iff (!rstn)
        pushValid_r |-> pushData_r[15:12] == 4'hF)
        else $error("readback upper bits not all one");

    chk_write_step: assert property (@(posedge sys_clk) disable iff (!rstn)
        memWe_r |-> cop_r == stepPoint({memAddrX_r, memAddrY_r}, scan_r,
            winL_r, winT_r, winR_r, winB_r))
        else $error("point not one step past written pixel");

    chk_read_step: assert property (@(posedge sys_clk) disable iff (!rstn)
        memRd_r |-> cop_r == stepPoint({memAddrX_r, memAddrY_r}, scan_r,
            winL_r, winT_r, winR_r, winB_r))
        else $error("point not one step past read pixel");

    chk_color_force: assert property (@(posedge sys_clk) disable iff (!rstn)
        (memWe_r && bk_r) |-> memWdata_r == $past(foreground))
        else $error("foreground not forced with color flag");

    chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_r == img_xfer_pkg::ST_IDLE && $past(state_r) ==
            img_xfer_pkg::ST_IDLE) |-> !memRd_r && !pushValid_r)
        else $error("readback activity while idle");

    chk_odd_length: assert property (@(posedge sys_clk) disable iff (!rstn)
        (take && state_r == img_xfer_pkg::ST_LEN) |=>
            wordsLeft_r == $past(cmdWord[15:1]))
        else $error("word count not half the even byte count");

    chk_corner_start: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_r == img_xfer_pkg::ST_SETUP && !en_r[2] && en_r[1]) |=>
            cop_r == corner(scan_r, winL_r, winT_r, winR_r, winB_r))
        else $error("start pixel not at scan corner");

    chk_read_turnaround: assert property (@(posedge sys_clk) disable iff (!rstn)
        memRd_r |-> !memWe_r ##1 (state_r == img_xfer_pkg::ST_RD_WAIT))
        else $error("read strobe outside read phase");
endmodule
`default_nettype wire

/* File: mem_model.sv */
// refresh memory stand-in with a random read delay
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // memory port of the engine
    input wire logic sys_clk,
    input wire logic [9:0] memAddrX,
    input wire logic [9:0] memAddrY,
    input wire logic memWe,
    input wire logic [11:0] memWdata,
    input wire logic [11:0] memWmask,
    input wire logic memRd,
    output logic memRdValid,
    output logic [11:0] memRdData
);
    logic [11:0] mem [0:1048575];
    logic [19:0] key;
    logic [19:0] key_r;
    int lat = 0;
    initial {memRdValid, memRdData} = 13'h0000;
    // idle data toggles so a stale word never passes for an answer
    always @(posedge sys_clk) begin
        key = {memAddrX, memAddrY};
        memRdValid <= 1'b0;
        memRdData <= ~memRdData;
        if (memWe)
            mem[key] <= (mem[key] & ~memWmask) | (memWdata & memWmask);
        if (memRd)
            lat <= 1 + $urandom % 3;
        else if (lat > 0)
            lat <= lat - 1;
        if (memRd)
            key_r <= key;
        if (!memRd && lat == 1)
            {memRdValid, memRdData} <= {1'b1, mem[key_r]};
    end
endmodule
`default_nettype wire

/* File: test_image_window_transfer.sv */
// self-checking bench for the image window transfer engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
$display("mismatch %s expected %h seen %h", nm, e, s); end end
module test_image_window_transfer;
    logic sys_clk, rstn, cmdValid, cmdReady, hostRdValid, hostRdReady;
    logic memWe, memRd, memRdValid, busy;
    logic [15:0] cmdWord, hostRdData, want, hdr[8], dat[17];
    logic [11:0] fg, sc, memWdata, memWmask, memRdData;
    logic [9:0] ix[4], memAddrX, memAddrY, copX, copY, ox, oy;
    logic [1:0] sel;
    int failures = 0, checked = 0, got, n, base;
    image_window_transfer DUT (.sys_clk, .rstn, .cmdValid, .cmdWord,
        .cmdReady, .hostRdValid, .hostRdData, .hostRdReady,
        .subchannel(sc), .foreground(fg), .index1X(ix[0]),
        .index1Y(ix[1]), .index2X(ix[2]), .index2Y(ix[3]), .memAddrX,
        .memAddrY, .memWe, .memWdata, .memWmask, .memRd, .memRdValid,
        .memRdData, .busy, .copX, .copY);
    mem_model partner (.sys_clk, .memAddrX, .memAddrY, .memWe, .memWdata,
        .memWmask, .memRd, .memRdValid, .memRdData);
    always #2.5 sys_clk = ~sys_clk;
    // k-th pixel {x, y} of the 4x4 window at 100,100 for a scan mode
    function automatic logic [19:0] pos(logic [2:0] m, int k);
        int x, y;
        x = m[2] ? (k / 4) % 4 : k % 4;
        y = m[2] ? k % 4 : (k / 4) % 4;
        if (m[2] ? m[1] : m[0]) x = 3 - x;
        if (m[2] ? m[0] : m[1]) y = 3 - y;
        return {10'(x + 100), 10'(y + 100)};
    endfunction
    // stored word at the k-th pixel of mode m
    function automatic logic [11:0] px(int m, int k);
        return partner.mem[pos(3'(m), k)];
    endfunction
    // offer one host word; ready is read settled, then one edge takes it
    task automatic send(logic [15:0] w);
        int t = 0;
        cmdValid = 1'b1;
        cmdWord = w;
        while (cmdReady !== 1'b1 && t < 99) begin
            @(posedge sys_clk);
            #1 t++;
        end
        if (t == 99) failures++;
        @(posedge sys_clk);
        #1;
    endtask
    // back to idle, then two edges so the last write lands
    task automatic settle;
        int t = 0;
        cmdValid = 1'b0;
        while (busy !== 1'b0 && t < 999) begin
            @(posedge sys_clk);
            #1 t++;
        end
        if (t == 999) failures++;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence: every scan mode writes 17 words, then reads 16 back
    initial begin
        {sys_clk, rstn, cmdValid, hostRdReady, cmdWord} = 20'h00000;
        got = $urandom(32'h04932907);
        fg = 12'($urandom);
        foreach (ix[i]) ix[i] = 10'($urandom);
        repeat (6) @(posedge sys_clk);
        #1 rstn = 1'b1;
        @(posedge sys_clk);
        #1;
        for (int m = 0; m < 8; m++) begin
            // index select cycles 0,1,2; operands pre-offset to land at 100
            sc = 12'hFFF;
            sel = 2'(m % 3);
            ox = (sel == 2'h1) ? ix[0] : ((sel == 2'h2) ? ix[2] : 10'h000);
            oy = (sel == 2'h1) ? ix[1] : ((sel == 2'h2) ? ix[3] : 10'h000);
            foreach (dat[k]) dat[k] = 16'($urandom);
            hdr = '{16'h0A03, 16'h00C0, 16'(m), 16'(10'(100 - ox)),
                16'(10'(100 - oy)), 16'(10'(103 - ox)),
                16'(10'(103 - oy)), 16'h0023};
            hdr[0] = {8'h0A, 3'h0, sel, 1'(m == 5), 2'h3};
            foreach (hdr[i]) send(hdr[i]);
            foreach (dat[k]) send(dat[k]);
            settle();
            for (int k = 1; k < 16; k++) begin
                want = (m == 5) ? 16'(fg) : dat[k];
                `CHK("pixel", want[11:0], px(m, k))
            end
            want = (m == 5) ? 16'(fg) : dat[16];
            `CHK("wrap", want[11:0], px(m, 0))
            `CHK("cop write", pos(3'(m), 1), {copX, copY})
            // odd modes read from an explicit start at the corner
            base = (m % 2 == 0) ? 1 : 0;
            if (base == 0) begin
                send(16'h0B03);
                send(16'h0020);
                send(16'(pos(3'(m), 0) >> 10));
                send(16'(10'(pos(3'(m), 0))));
            end else begin
                send(16'h0B02);
            end
            send(16'h0020);
            cmdValid = 1'b0;
            {got, n} = 0;
            sc = 12'($urandom);
            while (got < 16 && n < 999) begin
                hostRdReady = 1'($urandom);
                want = {4'hF, px(m, got + base)};
                if (hostRdValid === 1'b1 && hostRdReady) begin
                    `CHK("readback", want, hostRdData)
                    got++;
                end
                @(posedge sys_clk);
                #1 n++;
            end
            hostRdReady = 1'b0;
            `CHK("read count", 16, got)
            settle();
            `CHK("cop read", pos(3'(m), base), {copX, copY})
        end
        send(16'h0B00);
        settle();
        `CHK("no length", 1'b0, hostRdValid)
        tally_and_finish();
    end
    // eight modes need about 1100 cycles; an eighteenfold margin cuts hangs
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
